//--- bench/line_diagnostics_control_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Port checker for the diagnostics register bank.
// ------------------------------------------------------------
module line_diagnostics_control_regs_chk (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [9:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        mclkEn,
    input wire logic [3:0]  txClkEn,
    input wire logic [3:0]  los,
    input wire logic [3:0]  rxPosIn,
    input wire logic [3:0]  txLineData,
    input wire logic [3:0]  rxPositiveDataOut,
    input wire logic [3:0]  patternRefClockSelect,
    input wire logic [3:0]  detectCriterionSelect,
    input wire logic [3:0]  autoFarLoopEnable,
    input wire logic [3:0]  farLoopEnable,
    input wire logic [3:0]  analogLoopEnable,
    input wire logic [3:0]  digitalLoopEnable,
    input wire logic [7:0]  rxActivateLength,
    input wire logic [7:0]  rxDeactivateLength
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // A request is taken only while no answer is on the bus.
    logic taken;
    logic wrOk;
    assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wrOk  = taken && wb_we_i && wb_sel_i[0];

    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    chk_ack_latency: assert property (taken |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    chk_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    chk_unmapped_zero: assert property (taken && !wb_we_i &&
        (wb_adr_i[7:2] < 6'h0a || wb_adr_i[7:2] > 6'h0f) |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    chk_loop_mirror: assert property (wrOk && wb_adr_i == 10'h22c |-> ##2
        {autoFarLoopEnable[2], farLoopEnable[2], analogLoopEnable[2],
         digitalLoopEnable[2]} == $past(wb_dat_i[3:0], 2))
        else $error("loopback controls do not follow write");
    chk_crit_mirror: assert property (wrOk && wb_adr_i == 10'h028 |-> ##2
        {patternRefClockSelect[0], detectCriterionSelect[0]}
        == $past({wb_dat_i[4], wb_dat_i[2]}, 2))
        else $error("clock or criterion select does not follow write");
    chk_len_mirror: assert property (wrOk && wb_adr_i == 10'h230 |-> ##2
        {rxActivateLength[5:4], rxDeactivateLength[5:4]} == $past(wb_dat_i[3:0], 2))
        else $error("receive lengths do not follow write");
    chk_rx_pass: assert property (!los[0] |=> rxPositiveDataOut[0] == $past(rxPosIn[0]))
        else $error("receive data replaced without loss");
    chk_tx_enable: assert property ($changed(txLineData[0]) |-> $past(mclkEn || txClkEn[0]))
        else $error("transmit bit moved without clock enable");
endmodule // line_diagnostics_control_regs_chk

bind line_diagnostics_control_regs line_diagnostics_control_regs_chk u_chk (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .mclkEn(mclkEn), .txClkEn(txClkEn), .los(los), .rxPosIn(rxPosIn),
    .txLineData(txLineData), .rxPositiveDataOut(rxPositiveDataOut),
    .patternRefClockSelect(patternRefClockSelect),
    .detectCriterionSelect(detectCriterionSelect),
    .autoFarLoopEnable(autoFarLoopEnable), .farLoopEnable(farLoopEnable),
    .analogLoopEnable(analogLoopEnable), .digitalLoopEnable(digitalLoopEnable),
    .rxActivateLength(rxActivateLength), .rxDeactivateLength(rxDeactivateLength));

`default_nettype wire

//--- bench/tb_line_diagnostics_control_regs.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end

module tb_line_diagnostics_control_regs;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, e1Mode, mclkEn;
    logic        wb_ack_o, b;
    logic [9:0]  wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [31:0] rxActivateCodeValue, rxDeactivateCodeValue;
    logic [3:0]  wb_sel_i, txClkEn, txData, los, rxPosIn, rxNegIn, rxClkIn;
    logic [3:0]  rxSeqIn, txLineData, rxPositiveDataOut, rxNegativeDataOut;
    logic [3:0]  rxClockOut, rxCheckData, patternRefClockSelect, lb;
    logic [3:0]  detectCriterionSelect, autoFarLoopEnable, farLoopEnable;
    logic [3:0]  analogLoopEnable, digitalLoopEnable;
    logic [7:0]  rxActivateLength, rxDeactivateLength, rd, code;
    logic [2:0]  rx3;
    logic [29:0] seq;
    int          fails = 0, nTests = 0, cycles = 0, ones, lag, tap;
    logic [7:0]  rstVal [6] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h09};
    logic [7:0]  wrMask [6] = '{8'h7f, 8'h0f, 8'h3f, 8'hff, 8'hff, 8'hff};

    line_diagnostics_control_regs uut (.*);

    // Free-running 250 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // The cycle ceiling is far above the few hundred cycles the run needs.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------
    // Bus and pattern helpers
    // ------------------------------------------------------------
    function automatic logic [9:0] ad(input int ch, input int idx);
        return {ch[1:0], idx[5:0], 2'b00};
    endfunction

    // One classic cycle; the request stays put until ack is sampled high.
    task automatic xfer(input logic we, input logic [9:0] a,
                        input logic [7:0] d, input logic [3:0] s);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= {24'h0, d};
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        xfer(1'b1, a, d, 4'h1);
    endtask

    task automatic rdc(input logic [9:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00, 4'h1);
        `CHK(rd, e)
    endtask

    // One enable pulse on channel 0; the launched bit lands in b.
    task automatic pulse(input logic useM);
        mclkEn  <= useM;
        txClkEn <= {3'b000, !useM};
        @(posedge clk);
        mclkEn  <= 1'b0;
        txClkEn <= 4'h0;
        @(posedge clk);
        b = txLineData[0];
    endtask

    // One pulse, then the launched bit is compared.
    task automatic txc(input logic useM, input logic e);
        pulse(useM);
        `CHK(b, e)
    endtask

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", nTests, fails);
        if (fails == 0 && nTests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, e1Mode, mclkEn} = '0;
        {wb_adr_i, wb_dat_i} = '0;
        {wb_sel_i, txClkEn, txData, los, rxPosIn, rxNegIn, rxClkIn} = '0;
        rxSeqIn = 4'h0;
        rst_n = 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int c = 0; c < 4; c++)
            for (int r = 0; r < 6; r++)
                rdc(ad(c, 10 + r), rstVal[r]);
        $display("Reset value test finished");
        for (int r = 0; r < 6; r++) begin
            wr(ad(2, 10 + r), 8'hff);
            rdc(ad(2, 10 + r), wrMask[r]);
            rdc(ad(1, 10 + r), rstVal[r]);
        end
        wr(ad(0, 32), 8'h5a);
        rdc(ad(0, 32), 8'h00);
        xfer(1'b1, ad(1, 13), 8'h77, 4'he);
        rdc(ad(1, 13), 8'h01);
        wr(ad(1, 14), 8'h5a);
        wr(ad(1, 15), 8'ha5);
        `CHK(rxActivateCodeValue[15:8], 8'h5a)
        `CHK(rxDeactivateCodeValue[15:8], 8'ha5)
        for (int v = 5; v < 11; v += 5) begin
            wr(ad(2, 11), v[7:0]);
            lb = {autoFarLoopEnable[2], farLoopEnable[2],
                  analogLoopEnable[2], digitalLoopEnable[2]};
            `CHK(lb, v[3:0])
        end
        wr(ad(0, 10), 8'h04);
        `CHK(({patternRefClockSelect[0], detectCriterionSelect[0]}), 2'b01)
        wr(ad(0, 10), 8'h10);
        `CHK(({patternRefClockSelect[0], detectCriterionSelect[0]}), 2'b10)
        $display("Register access test finished");
        txData <= 4'h1;
        wr(ad(0, 10), 8'h00);
        txc(1'b0, 1'b1);
        txData <= 4'h0;
        txc(1'b0, 1'b0);
        wr(ad(0, 10), 8'h20);
        txc(1'b0, 1'b1);
        wr(ad(0, 10), 8'h10);
        txc(1'b0, 1'b1);
        txc(1'b1, 1'b0);
        wr(ad(0, 10), 8'h21);
        txc(1'b0, 1'b0);
        los <= 4'h1;
        txc(1'b0, 1'b1);
        {rxPosIn, rxNegIn, rxClkIn} <= 12'hfff;
        repeat (2) @(posedge clk);
        rx3 = {rxPositiveDataOut[0], rxNegativeDataOut[0], rxClockOut[0]};
        `CHK(rx3, 3'b111)
        wr(ad(0, 10), 8'h02);
        `CHK(rxNegativeDataOut[0], ~rxPositiveDataOut[0])
        los <= 4'h0;
        repeat (2) @(posedge clk);
        rx3 = {rxPositiveDataOut[0], rxNegativeDataOut[0], rxClockOut[0]};
        `CHK(rx3, 3'b111)
        rxSeqIn <= 4'h1;
        wr(ad(0, 10), 8'h08);
        `CHK(rxCheckData[0], 1'b0)
        wr(ad(0, 10), 8'h00);
        `CHK(rxCheckData[0], 1'b1)
        $display("Pattern and alarm test finished");
        // Each run must obey its polynomial: bit n is the sum of bits
        // n-15 and n-14 (E1) or n-20 and n-17 (T1), plus the invert bit.
        ones = 0;
        for (int m = 0; m < 4; m++) begin
            e1Mode <= m[0];
            wr(ad(0, 10), m[1] ? 8'h48 : 8'h40);
            lag = m[0] ? 15 : 20;
            tap = m[0] ? 14 : 17;
            for (int k = 0; k < 30; k++) begin
                pulse(1'b0);
                seq[k] = b;
                ones += b;
                if (k >= lag)
                    `CHK(b, seq[k-lag] ^ seq[k-tap] ^ m[1])
            end
        end
        `CHK(ones > 0 && ones < 120, 1'b1)
        code = 8'hb5;
        wr(ad(0, 13), code);
        for (int n = 0; n < 4; n++) begin
            wr(ad(0, 12), {2'b00, n[1:0], 4'h1});
            wr(ad(0, 10), 8'h60);
            for (int k = 2 * n + 9; k >= 0; k--)
                txc(1'b0, code[k % (n + 5)]);
            wr(ad(0, 10), 8'h00);
        end
        $display("Sequence and code test finished");
        wrap_up();
    end
endmodule // tb_line_diagnostics_control_regs

`default_nettype wire

//--- inc/line_diag_defs.vh
`ifndef LINE_DIAG_DEFS_VH
`define LINE_DIAG_DEFS_VH

// ------------------------------------------------------------
// Register indices within one channel block (byte addr = 4 * index).
// ------------------------------------------------------------
`define IDX_PAT_ALARM   6'h0a
`define IDX_LOOPBACK    6'h0b
`define IDX_CODE_LEN    6'h0c
`define IDX_TX_CODE     6'h0d
`define IDX_RX_ACT      6'h0e
`define IDX_RX_DEACT    6'h0f
`define IDX_W           8
`define CH_HI           7
`define CH_LO           6
`define OFS_HI          5

// ------------------------------------------------------------
// Reset values and writable-bit masks.
// ------------------------------------------------------------
`define RST_PAT_ALARM   8'h00
`define RST_LOOPBACK    8'h00
`define RST_CODE_LEN    8'h01
`define RST_TX_CODE     8'h01
`define RST_RX_ACT      8'h01
`define RST_RX_DEACT    8'h09
`define MSK_PAT_ALARM   8'h7f
`define MSK_LOOPBACK    8'h0f
`define MSK_CODE_LEN    8'h3f
`define MSK_FULL        8'hff

// ------------------------------------------------------------
// Field positions.
// ------------------------------------------------------------
`define TX_PATTERN_SELECT_HI         6
`define TX_PATTERN_SELECT_LO         5
`define PCLK_BIT        4
`define INV_BIT         3
`define CRIT_BIT        2
`define ALARM_INSERT_ENABLE_BIT        1
`define AUTO_ALL_ONES_ENABLE_BIT        0
`define AUTO_FAR_LOOP_ENABLE_BIT        3
`define RLP_BIT         2
`define ALP_BIT         1
`define DLP_BIT         0
`define TXLEN_HI        5
`define TXLEN_LO        4
`define RXALEN_HI       3
`define RXALEN_LO       2
`define RXDLEN_HI       1
`define RXDLEN_LO       0

// ------------------------------------------------------------
// Pattern selections and sequence generator constants.
// ------------------------------------------------------------
`define PAT_NORMAL      2'h0
`define PAT_ONES        2'h1
`define PAT_PRBS        2'h2
`define PAT_CODE        2'h3
`define MIN_CODE_LEN    3'h4
`define E1_TAP_A        14
`define E1_TAP_B        13
`define T1_TAP_A        19
`define T1_TAP_B        16
`define LFSR_SEED       20'h00001

`endif

//--- verilog/line_diagnostics_control_regs.v
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "line_diag_defs.vh"

module line_diagnostics_control_regs (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [9:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output wire        wb_ack_o,
    input  wire        e1Mode,
    input  wire        mclkEn,
    input  wire [3:0]  txClkEn,
    input  wire [3:0]  txData,
    input  wire [3:0]  los,
    input  wire [3:0]  rxPosIn,
    input  wire [3:0]  rxNegIn,
    input  wire [3:0]  rxClkIn,
    input  wire [3:0]  rxSeqIn,
    output reg  [3:0]  txLineData,
    output reg  [3:0]  rxPositiveDataOut,
    output reg  [3:0]  rxNegativeDataOut,
    output reg  [3:0]  rxClockOut,
    output reg  [3:0]  rxCheckData,
    output reg  [3:0]  patternRefClockSelect,
    output reg  [3:0]  detectCriterionSelect,
    output reg  [3:0]  autoFarLoopEnable,
    output reg  [3:0]  farLoopEnable,
    output reg  [3:0]  analogLoopEnable,
    output reg  [3:0]  digitalLoopEnable,
    output reg  [7:0]  rxActivateLength,
    output reg  [7:0]  rxDeactivateLength,
    output reg  [31:0] rxActivateCodeValue,
    output reg  [31:0] rxDeactivateCodeValue
);

    // ------------------------------------------------------------
    // Storage and helpers.
    // ------------------------------------------------------------

    // One copy of each channel register per channel, indexed by channel; ack and alarm timing registers are shared.
    reg [7:0]  patAlarm_reg [0:3];
    reg [7:0]  loopback_reg [0:3];
    reg [7:0]  codeLen_reg  [0:3];
    reg [7:0]  txCode_reg   [0:3];
    reg [7:0]  rxAct_reg    [0:3];
    reg [7:0]  rxDeact_reg  [0:3];
    reg [19:0] lfsr_reg     [0:3];
    reg [2:0]  codePtr_reg  [0:3];
    reg        ack_reg;
    reg        aisPhase_reg;
    reg        aisBit_reg;

    // ------------------------------------------------------------
    // Address decoding.
    // ------------------------------------------------------------

    // The word index drops the byte lanes; its top two bits pick the
    // channel, which puts the four copies one 0x40 block apart.
    wire [`IDX_W-1:0]  regIdx = wb_adr_i[9:2];
    wire [1:0]         chSel  = regIdx[`CH_HI:`CH_LO];
    wire [`OFS_HI:0]   ofs    = regIdx[`OFS_HI:0];
    wire               busReq = wb_cyc_i & wb_stb_i;

    // A request is taken only while ack is low, so a master that keeps
    // its strobe up through the ack cycle does not write the same word again there.
    wire               wrEn   = busReq & wb_we_i & wb_sel_i[0] & ~ack_reg;

    // ------------------------------------------------------------
    // Helper functions.
    // ------------------------------------------------------------

    // Highest bit index of a repeating code for a two-bit length code.
    function [2:0] codeTop;
        input [1:0] lenCode;
        begin
            codeTop = `MIN_CODE_LEN + {1'b0, lenCode};
        end
    endfunction

    // Read value of one register of one channel, zero when unmapped.
    function [7:0] readReg;
        input [`OFS_HI:0] o;
        input [7:0] pa;
        input [7:0] lb;
        input [7:0] cl;
        input [7:0] tc;
        input [7:0] ra;
        input [7:0] rd;
        begin
            case (o)
                `IDX_PAT_ALARM: readReg = pa;
                `IDX_LOOPBACK:  readReg = lb;
                `IDX_CODE_LEN:  readReg = cl;
                `IDX_TX_CODE:   readReg = tc;
                `IDX_RX_ACT:    readReg = ra;
                `IDX_RX_DEACT:  readReg = rd;
                default:        readReg = 8'h00;
            endcase
        end
    endfunction

    // Next state of the shared-width sequence generator.
    function [19:0] lfsrStep;
        input [19:0] s;
        input        e1;
        reg          fb;
        reg          dead;
        begin
            fb   = 1'b0;
            dead = 1'b0;
            if (e1) begin
                fb   = s[`E1_TAP_A] ^ s[`E1_TAP_B];
                dead = ~|s[`E1_TAP_A:0];
            end else begin
                fb   = s[`T1_TAP_A] ^ s[`T1_TAP_B];
                dead = ~|s;
            end
            // A zero state would lock up; reseed it instead.
            lfsrStep = {s[18:0], fb | dead};
        end
    endfunction

    // Clock enable of one channel's pattern logic: the master clock
    // enable when the reference bit is set, else the channel's own.
    function patternTick;
        input refSel;
        input masterEn;
        input chanEn;
        begin
            patternTick = refSel ? masterEn : chanEn;
        end
    endfunction

    // ------------------------------------------------------------
    // Wishbone classic slave.
    // ------------------------------------------------------------

    // Single-cycle answer; ack drops the cycle after it was given.
    // Read data is refreshed every cycle from the held address, so it
    // stands unchanged in the ack cycle where the master takes it.
    always @(posedge clk) begin
        if (!rst_n) begin
            ack_reg  <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            ack_reg  <= busReq & ~ack_reg;
            wb_dat_o <= {24'h000000,
                         readReg(ofs, patAlarm_reg[chSel],
                                 loopback_reg[chSel], codeLen_reg[chSel],
                                 txCode_reg[chSel], rxAct_reg[chSel],
                                 rxDeact_reg[chSel])};
        end
    end

    assign wb_ack_o = ack_reg;

    // Register writes; only the low byte lane carries data.
    always @(posedge clk) begin : regWriteProc
        integer i;
        if (!rst_n) begin
            for (i = 0; i < 4; i = i + 1) begin
                patAlarm_reg[i] <= `RST_PAT_ALARM;
                loopback_reg[i] <= `RST_LOOPBACK;
                codeLen_reg[i]  <= `RST_CODE_LEN;
                txCode_reg[i]   <= `RST_TX_CODE;
                rxAct_reg[i]    <= `RST_RX_ACT;
                rxDeact_reg[i]  <= `RST_RX_DEACT;
            end
        end else if (wrEn) begin
            // Masks keep reserved bits at zero whatever is written.
            case (ofs)
                `IDX_PAT_ALARM:
                    patAlarm_reg[chSel] <= wb_dat_i[7:0] & `MSK_PAT_ALARM;
                `IDX_LOOPBACK:
                    loopback_reg[chSel] <= wb_dat_i[7:0] & `MSK_LOOPBACK;
                `IDX_CODE_LEN:
                    codeLen_reg[chSel]  <= wb_dat_i[7:0] & `MSK_CODE_LEN;
                `IDX_TX_CODE:
                    txCode_reg[chSel]   <= wb_dat_i[7:0] & `MSK_FULL;
                `IDX_RX_ACT:
                    rxAct_reg[chSel]    <= wb_dat_i[7:0] & `MSK_FULL;
                `IDX_RX_DEACT:
                    rxDeact_reg[chSel]  <= wb_dat_i[7:0] & `MSK_FULL;
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Alarm signal timing.
    // ------------------------------------------------------------

    // The substitute receive clock runs from the master clock enable,
    // since the recovered clock is meaningless while the line is lost.
    // Each substitute bit spans one full period of that clock.
    always @(posedge clk) begin
        if (!rst_n) begin
            aisPhase_reg <= 1'b0;
            aisBit_reg   <= 1'b0;
        end else if (mclkEn) begin
            aisPhase_reg <= ~aisPhase_reg;
            if (aisPhase_reg) begin
                aisBit_reg <= ~aisBit_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // Per-channel transmit pattern engine.
    // ------------------------------------------------------------

    // Sequence generator and code pointer advance on the chosen clock.
    // The generator runs whatever the pattern, so a switch to the
    // sequence picks up mid-stream instead of restarting from the seed.
    always @(posedge clk) begin : patternGenProc
        integer i;
        if (!rst_n) begin
            for (i = 0; i < 4; i = i + 1) begin
                lfsr_reg[i]    <= `LFSR_SEED;
                codePtr_reg[i] <= `MIN_CODE_LEN;
            end
        end else begin
            for (i = 0; i < 4; i = i + 1) begin
                if (patternTick(patAlarm_reg[i][`PCLK_BIT], mclkEn,
                                txClkEn[i])) begin
                    lfsr_reg[i] <= lfsrStep(lfsr_reg[i], e1Mode);
                end
                if (patAlarm_reg[i][`TX_PATTERN_SELECT_HI:`TX_PATTERN_SELECT_LO] != `PAT_CODE) begin
                    // Park on the top bit so the code starts MSB first.
                    codePtr_reg[i] <= codeTop(
                        codeLen_reg[i][`TXLEN_HI:`TXLEN_LO]);
                end else if (patternTick(patAlarm_reg[i][`PCLK_BIT],
                                         mclkEn, txClkEn[i])) begin
                    if (codePtr_reg[i] == 3'h0) begin
                        codePtr_reg[i] <= codeTop(
                            codeLen_reg[i][`TXLEN_HI:`TXLEN_LO]);
                    end else begin
                        codePtr_reg[i] <= codePtr_reg[i] - 3'h1;
                    end
                end
            end
        end
    end

    // Transmit data selection, held between clock enables. Normal data
    // is retimed by one tick like the patterns, so every source leaves
    // on the same edge and a pattern switch lines up with the bit grid.
    always @(posedge clk) begin : txSelectProc
        integer i;
        if (!rst_n) begin
            txLineData <= 4'h0;
        end else begin
            for (i = 0; i < 4; i = i + 1) begin
                if (patternTick(patAlarm_reg[i][`PCLK_BIT], mclkEn,
                                txClkEn[i])) begin
                    case (patAlarm_reg[i][`TX_PATTERN_SELECT_HI:`TX_PATTERN_SELECT_LO])
                        `PAT_NORMAL:
                            // Master reference with no pattern sends zeros.
                            txLineData[i] <= ~patAlarm_reg[i][`PCLK_BIT]
                                             & txData[i];
                        `PAT_ONES:
                            // With auto mode the ones go out only on loss.
                            txLineData[i] <= patAlarm_reg[i][`AUTO_ALL_ONES_ENABLE_BIT] ?
                                             (los[i] | txData[i]) :
                                             1'b1;
                        `PAT_PRBS:
                            txLineData[i] <= (e1Mode ?
                                lfsr_reg[i][`E1_TAP_A] :
                                lfsr_reg[i][`T1_TAP_A]) ^
                                patAlarm_reg[i][`INV_BIT];
                        `PAT_CODE:
                            txLineData[i] <=
                                txCode_reg[i][codePtr_reg[i]];
                        default:
                            txLineData[i] <= txData[i];
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Receive path substitution and checker input.
    // ------------------------------------------------------------

    // Alarm replaces data and clock only while loss persists, so a
    // recovering line returns to live data on the next cycle.
    always @(posedge clk) begin : rxPathProc
        integer i;
        if (!rst_n) begin
            rxPositiveDataOut <= 4'h0;
            rxNegativeDataOut <= 4'h0;
            rxClockOut        <= 4'h0;
            rxCheckData       <= 4'h0;
        end else begin
            for (i = 0; i < 4; i = i + 1) begin
                if (patAlarm_reg[i][`ALARM_INSERT_ENABLE_BIT] & los[i]) begin
                    rxPositiveDataOut[i] <= aisBit_reg;
                    rxNegativeDataOut[i] <= ~aisBit_reg;
                    rxClockOut[i]        <= aisPhase_reg;
                end else begin
                    rxPositiveDataOut[i] <= rxPosIn[i];
                    rxNegativeDataOut[i] <= rxNegIn[i];
                    rxClockOut[i]        <= rxClkIn[i];
                end
                rxCheckData[i] <= rxSeqIn[i] ^
                                  patAlarm_reg[i][`INV_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // Control outputs to the line and receive blocks.
    // ------------------------------------------------------------

    // Registered copies keep the outputs glitch free and flop driven.
    // They trail the register by one cycle, far below any line rate.
    always @(posedge clk) begin : ctlCopyProc
        integer i;
        if (!rst_n) begin
            patternRefClockSelect <= 4'h0;
            detectCriterionSelect <= 4'h0;
            autoFarLoopEnable     <= 4'h0;
            farLoopEnable         <= 4'h0;
            analogLoopEnable      <= 4'h0;
            digitalLoopEnable     <= 4'h0;
            rxActivateLength      <= 8'h00;
            rxDeactivateLength    <= 8'h00;
            rxActivateCodeValue   <= 32'h00000000;
            rxDeactivateCodeValue <= 32'h00000000;
        end else begin
            for (i = 0; i < 4; i = i + 1) begin
                patternRefClockSelect[i] <= patAlarm_reg[i][`PCLK_BIT];
                detectCriterionSelect[i] <=
                    patAlarm_reg[i][`CRIT_BIT];
                autoFarLoopEnable[i] <= loopback_reg[i][`AUTO_FAR_LOOP_ENABLE_BIT];
                farLoopEnable[i]     <= loopback_reg[i][`RLP_BIT];
                analogLoopEnable[i]  <= loopback_reg[i][`ALP_BIT];
                digitalLoopEnable[i] <= loopback_reg[i][`DLP_BIT];
                rxActivateLength[2*i +: 2] <=
                    codeLen_reg[i][`RXALEN_HI:`RXALEN_LO];
                rxDeactivateLength[2*i +: 2] <=
                    codeLen_reg[i][`RXDLEN_HI:`RXDLEN_LO];
                rxActivateCodeValue[8*i +: 8]   <= rxAct_reg[i];
                rxDeactivateCodeValue[8*i +: 8] <= rxDeact_reg[i];
            end
        end
    end

endmodule // line_diagnostics_control_regs

`default_nettype wire
